// ---- src/empd_ext_mem.sv ----
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module empd_ext_mem
	import empd_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite register slave.
	input wire logic [EMPD_AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [EMPD_AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Processor access port.
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [15:0] cpu_addr,
	input wire logic [15:0] cpu_wdata,
	input wire logic [1:0] cpu_be,
	output logic cpu_ack,
	output logic [15:0] cpu_rdata,
	output logic cpu_ext,
	// DMA address aliasing.
	input wire logic [15:0] dma_addr,
	output logic [15:0] dma_int_addr,
	// External memory pins.
	output logic [18:1] ext_addr,
	output logic low_byte_enable_n,
	output logic high_byte_enable_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic paged_window_select_n,
	output logic ram_chip_select_n,
	output logic rom_chip_select_n,
	input wire logic [15:0] ext_data_in,
	output logic [15:0] ext_data_out,
	output logic ext_data_oe
);

	// Inclusive range test, shared by every chip-select decode.
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Byte-lane merge of a 16-bit register with bus write data.
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		lane_merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
	endfunction

	// Registers and state.
	logic [15:0] page_lo_q;
	logic [15:0] page_hi_q;
	logic [15:0] ctrl_q;
	logic [15:0] upper_q;
	empd_state_e state_q;
	logic [3:0] cnt_q;
	logic [15:0] addr_q;
	logic we_q;
	logic ack_ext_q;
	logic [15:0] rdata_q;
	logic [15:0] din_meta_q;
	logic [15:0] din_sync_q;
	logic [EMPD_AXI_AW-1:0] aw_q;
	logic aw_full_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic w_full_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rd_q;
	logic [1:0] rresp_q;
	logic [18:1] ext_addr_q;
	logic lbe_n_q;
	logic hbe_n_q;
	logic rd_n_q;
	logic wr_n_q;
	logic xsel_n_q;
	logic ramsel_n_q;
	logic romsel_n_q;
	logic [15:0] dout_q;
	logic oe_q;
	logic [15:0] dma_q;

	// Control fields seen by the access engine.
	wire [2:0] ws_field = ctrl_q[EMPD_CTRL_WS_LSB +: EMPD_CTRL_WS_W];
	wire ram_merge = ctrl_q[EMPD_CTRL_RAM_MERGE];
	wire rom_merge = ctrl_q[EMPD_CTRL_ROM_MERGE];
	wire wide = ctrl_q[EMPD_CTRL_WIDE];
	wire upper_en = upper_q[EMPD_UPPER_EN];

	// Chip-select decode of the requested address; the hole matches no select.
	wire in_hole = in_range(cpu_addr, EMPD_HOLE_LO, EMPD_HOLE_HI);
	wire dec_xmem = in_range(cpu_addr, EMPD_WIN_LO, EMPD_WIN_HI);
	wire dec_ram = in_range(cpu_addr, EMPD_RAM_LO, EMPD_RAM_HI)
		|| (ram_merge && in_range(cpu_addr, EMPD_RAM_LO, EMPD_WIN_HI));
	wire dec_rom = in_range(cpu_addr, EMPD_ROM_LO, EMPD_ROM_HI)
		|| (rom_merge && in_range(cpu_addr, EMPD_WIN_LO, EMPD_ROM_HI) && !in_hole);
	wire dec_ext = dec_xmem || dec_ram || dec_rom;

	// Strobe length: one base cycle plus at least one wait state, each one cycle long.
	wire [2:0] ws_eff = (ws_field < EMPD_WS_MIN) ? EMPD_WS_MIN : ws_field;
	wire [3:0] strobe_cyc = 4'(1 + int'(ws_eff) * EMPD_WS_STEP_CYC);

	// Pin address: the window bank register replaces the upper bits inside 0x8000-0xBFFF.
	wire [15:0] page_sel = cpu_addr[13] ? page_hi_q : page_lo_q;
	wire [18:13] upper_bits = dec_xmem ? page_sel[5:0] : {3'h0, cpu_addr[15:13]};
	wire [18:15] forced_top = upper_en ? upper_bits[18:15] : 4'hF;
	wire [18:1] addr_next = {forced_top, upper_bits[14:13], cpu_addr[12:1]};

	// Byte lanes: two enables when wide, low enable carries A0 when narrow.
	wire lbe_next = wide ? ~cpu_be[0] : cpu_addr[0];
	wire hbe_next = wide ? ~cpu_be[1] : 1'b1;
	wire [15:0] dout_next = wide ? cpu_wdata
		: {8'h00, cpu_addr[0] ? cpu_wdata[15:8] : cpu_wdata[7:0]};
	wire [15:0] rd_capture = wide ? din_sync_q
		: (addr_q[0] ? {din_sync_q[7:0], 8'h00} : {8'h00, din_sync_q[7:0]});

	// Access engine; it runs from reset on, so boot code can fetch at once.
	// The count runs two cycles past the strobe's rise, so the word seen at that rise
	// has crossed the synchroniser before it is taken; a short strobe would otherwise
	// hand back the word from before the access.
	wire start = (state_q == EMPD_IDLE) && cpu_req;
	wire strobe_end = (state_q == EMPD_STROBE) && (cnt_q == EMPD_SYNC_CYC + 4'h1);
	wire last_cyc = (state_q == EMPD_STROBE) && (cnt_q == 4'h1);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= EMPD_IDLE;
			cnt_q <= 4'h0;
		end
		else
		begin
			case (state_q)
				EMPD_IDLE:
				begin
					if (cpu_req)
						state_q <= dec_ext ? EMPD_STROBE : EMPD_DONE;
					cnt_q <= 4'(strobe_cyc + EMPD_SYNC_CYC);
				end
				EMPD_STROBE:
				begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1)
						state_q <= EMPD_DONE;
				end
				EMPD_DONE: state_q <= EMPD_IDLE;
				default: state_q <= EMPD_IDLE;
			endcase
		end
	end

	// Request capture and answer data; the read word is the one seen at the strobe's rise.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			addr_q <= 16'h0000;
			we_q <= 1'b0;
			ack_ext_q <= 1'b0;
			rdata_q <= 16'h0000;
		end
		else if (start)
		begin
			addr_q <= cpu_addr;
			we_q <= cpu_we;
			ack_ext_q <= dec_ext;
			rdata_q <= 16'h0000;
		end
		else if (last_cyc && !we_q)
			rdata_q <= rd_capture;
	end

	// Pin data is asynchronous; two stages before anything reads it.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			din_meta_q <= 16'h0000;
			din_sync_q <= 16'h0000;
		end
		else
		begin
			din_meta_q <= ext_data_in;
			din_sync_q <= din_meta_q;
		end
	end

	// Pin drivers. Selects stay low while the read word crosses the synchroniser.
	// Strobes are only driven with a select, but the memory should still qualify them.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_addr_q <= {4'hF, 14'h0000};
			lbe_n_q <= 1'b1;
			hbe_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			xsel_n_q <= 1'b1;
			ramsel_n_q <= 1'b1;
			romsel_n_q <= 1'b1;
			dout_q <= 16'h0000;
			oe_q <= 1'b0;
		end
		else if (start && dec_ext)
		begin
			ext_addr_q <= addr_next;
			lbe_n_q <= lbe_next;
			hbe_n_q <= hbe_next;
			rd_n_q <= cpu_we;
			wr_n_q <= ~cpu_we;
			xsel_n_q <= ~dec_xmem;
			ramsel_n_q <= ~dec_ram;
			romsel_n_q <= ~dec_rom;
			dout_q <= dout_next;
			oe_q <= cpu_we;
		end
		else if (strobe_end)
		begin
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
		end
		else if (state_q == EMPD_DONE)
		begin
			ext_addr_q <= upper_en ? ext_addr_q : {4'hF, ext_addr_q[14:1]};
			lbe_n_q <= 1'b1;
			hbe_n_q <= 1'b1;
			xsel_n_q <= 1'b1;
			ramsel_n_q <= 1'b1;
			romsel_n_q <= 1'b1;
			oe_q <= 1'b0;
		end
	end

	// DMA has no range check: clearing bit 15 folds an external target into internal space.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			dma_q <= 16'h0000;
		else
			dma_q <= dma_addr & EMPD_DMA_MASK;
	end

	// AXI4-Lite write path: address and data are taken in either order.
	wire [15:0] aw_idx = aw_q[EMPD_AXI_AW-1:2];
	wire do_write = aw_full_q && w_full_q && !bvalid_q;
	wire aw_mapped = (aw_idx == EMPD_IDX_PAGE_LO) || (aw_idx == EMPD_IDX_PAGE_HI)
		|| (aw_idx == EMPD_IDX_CTRL) || (aw_idx == EMPD_IDX_UPPER)
		|| (aw_idx == EMPD_IDX_STATUS);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q <= '0;
			aw_full_q <= 1'b0;
			wd_q <= 32'h00000000;
			ws_q <= 4'h0;
			w_full_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= EMPD_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q <= s_axi_awaddr;
				aw_full_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
				w_full_q <= 1'b1;
			end
			if (do_write)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= aw_mapped ? EMPD_RESP_OKAY : EMPD_RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Software-visible registers; the status word is read-only.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			page_lo_q <= EMPD_PAGE_RST;
			page_hi_q <= EMPD_PAGE_RST;
			ctrl_q <= EMPD_CTRL_RST;
			upper_q <= EMPD_UPPER_RST;
		end
		else if (do_write)
		begin
			if (aw_idx == EMPD_IDX_PAGE_LO)
				page_lo_q <= lane_merge(page_lo_q, wd_q, ws_q);
			if (aw_idx == EMPD_IDX_PAGE_HI)
				page_hi_q <= lane_merge(page_hi_q, wd_q, ws_q);
			if (aw_idx == EMPD_IDX_CTRL)
				ctrl_q <= lane_merge(ctrl_q, wd_q, ws_q);
			if (aw_idx == EMPD_IDX_UPPER)
				upper_q <= lane_merge(upper_q, wd_q, ws_q);
		end
	end

	// AXI4-Lite read path: one outstanding read, answer one cycle after the address.
	wire [15:0] ar_idx = s_axi_araddr[EMPD_AXI_AW-1:2];
	wire [15:0] status_word = {11'h000, ack_ext_q, state_q, ~xsel_n_q, ~rd_n_q | ~wr_n_q};
	wire ar_mapped = (ar_idx == EMPD_IDX_PAGE_LO) || (ar_idx == EMPD_IDX_PAGE_HI)
		|| (ar_idx == EMPD_IDX_CTRL) || (ar_idx == EMPD_IDX_UPPER)
		|| (ar_idx == EMPD_IDX_STATUS);
	wire [15:0] ar_word = (ar_idx == EMPD_IDX_PAGE_LO) ? page_lo_q
		: (ar_idx == EMPD_IDX_PAGE_HI) ? page_hi_q
		: (ar_idx == EMPD_IDX_CTRL) ? ctrl_q
		: (ar_idx == EMPD_IDX_UPPER) ? upper_q
		: (ar_idx == EMPD_IDX_STATUS) ? status_word : 16'h0000;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rd_q <= 32'h00000000;
			rresp_q <= EMPD_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rd_q <= {16'h0000, ar_word};
			rresp_q <= ar_mapped ? EMPD_RESP_OKAY : EMPD_RESP_SLVERR;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// Port drive.
	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rresp_q;
	assign cpu_ack = (state_q == EMPD_DONE);
	assign cpu_rdata = rdata_q;
	assign cpu_ext = ack_ext_q;
	assign dma_int_addr = dma_q;
	assign ext_addr = ext_addr_q;
	assign low_byte_enable_n = lbe_n_q;
	assign high_byte_enable_n = hbe_n_q;
	assign read_strobe_n = rd_n_q;
	assign write_strobe_n = wr_n_q;
	assign paged_window_select_n = xsel_n_q;
	assign ram_chip_select_n = ramsel_n_q;
	assign rom_chip_select_n = romsel_n_q;
	assign ext_data_out = dout_q;
	assign ext_data_oe = oe_q;

	// Helper: strobe length and the length expected when the access started.
	logic [3:0] slen_q;
	logic [3:0] sexp_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			slen_q <= 4'h0;
			sexp_q <= 4'h0;
		end
		else
		begin
			slen_q <= (!rd_n_q || !wr_n_q) ? slen_q + 4'h1 : 4'h0;
			if (start)
				sexp_q <= strobe_cyc;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_strobe_open;
		$fell(read_strobe_n) || $fell(write_strobe_n);
	endsequence
	sequence s_strobe_close;
		$rose(read_strobe_n) || $rose(write_strobe_n);
	endsequence

	property p_min_wait;
		s_strobe_open |-> (!read_strobe_n || !write_strobe_n) [*2];
	endproperty
	a_min_wait: assert property (p_min_wait) else $error("strobe shorter than two cycles");

	property p_ws_len;
		s_strobe_close |-> (slen_q == sexp_q);
	endproperty
	a_ws_len: assert property (p_ws_len) else $error("strobe length off wait setting");

	property p_hole;
		(start && in_hole) |=> (paged_window_select_n && ram_chip_select_n
			&& rom_chip_select_n && read_strobe_n && write_strobe_n) [*2];
	endproperty
	a_hole: assert property (p_hole) else $error("hole access reached external bus");

	property p_xmem;
		start |=> (paged_window_select_n == !in_range(addr_q, EMPD_WIN_LO, EMPD_WIN_HI));
	endproperty
	a_xmem: assert property (p_xmem) else $error("paged select decode wrong");

	property p_ram;
		(start && !ram_merge && in_range(cpu_addr, 16'h8000, EMPD_WIN_HI))
			|=> ram_chip_select_n;
	endproperty
	a_ram: assert property (p_ram) else $error("RAM select active without merge");

	property p_rom;
		(start && rom_merge && in_range(cpu_addr, EMPD_WIN_LO, EMPD_WIN_HI))
			|=> !rom_chip_select_n;
	endproperty
	a_rom: assert property (p_rom) else $error("ROM merge did not cover window");

	property p_upper;
		!upper_en |-> ##1 (ext_addr[18:15] == 4'hF || $past(upper_en));
	endproperty
	a_upper: assert property (p_upper) else $error("upper address released early");

	property p_page;
		(start && dec_xmem && upper_en) |=> (ext_addr[18:13] == $past(page_sel[5:0]));
	endproperty
	a_page: assert property (p_page) else $error("window bank not on pins");

	property p_dma;
		##1 (dma_int_addr == ($past(dma_addr) & EMPD_DMA_MASK));
	endproperty
	a_dma: assert property (p_dma) else $error("DMA address not folded inward");

	property p_narrow_be;
		(start && dec_ext && !wide) |=> high_byte_enable_n
			&& (low_byte_enable_n == addr_q[0]);
	endproperty
	a_narrow_be: assert property (p_narrow_be) else $error("narrow byte lanes wrong");

endmodule

// ---- src/empd_pkg.sv ----
package empd_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [15:0] EMPD_IDX_PAGE_LO = 16'hC018;
	localparam logic [15:0] EMPD_IDX_PAGE_HI = 16'hC01A;
	localparam logic [15:0] EMPD_IDX_CTRL = 16'hC03A;
	localparam logic [15:0] EMPD_IDX_UPPER = 16'hC03C;
	localparam logic [15:0] EMPD_IDX_STATUS = 16'hC03E;
	localparam int EMPD_AXI_AW = 18;

	// Bus control fields.
	localparam int EMPD_CTRL_WS_LSB = 0;
	localparam int EMPD_CTRL_WS_W = 3;
	localparam int EMPD_CTRL_RAM_MERGE = 3;
	localparam int EMPD_CTRL_ROM_MERGE = 4;
	localparam int EMPD_CTRL_WIDE = 5;
	localparam int EMPD_UPPER_EN = 0;

	// Values after reset.
	localparam logic [15:0] EMPD_CTRL_RST = 16'h0007;
	localparam logic [15:0] EMPD_PAGE_RST = 16'h0000;
	localparam logic [15:0] EMPD_UPPER_RST = 16'h0000;

	// Processor address ranges.
	localparam logic [15:0] EMPD_RAM_LO = 16'h4000;
	localparam logic [15:0] EMPD_RAM_HI = 16'h7FFF;
	localparam logic [15:0] EMPD_WIN_LO = 16'h8000;
	localparam logic [15:0] EMPD_WIN_HI = 16'hBFFF;
	localparam logic [15:0] EMPD_HOLE_LO = 16'hC000;
	localparam logic [15:0] EMPD_HOLE_HI = 16'hC0FF;
	localparam logic [15:0] EMPD_ROM_LO = 16'hC100;
	localparam logic [15:0] EMPD_ROM_HI = 16'hDFFF;
	localparam logic [15:0] EMPD_DMA_MASK = 16'h7FFF;

	// Timing: one wait state lasts one processor cycle, rounded up to our clock.
	localparam int EMPD_CLK_PERIOD_NS = 25;
	localparam int EMPD_WS_STEP_NS = 21;
	localparam int EMPD_WS_STEP_CYC_RAW = (EMPD_WS_STEP_NS + EMPD_CLK_PERIOD_NS - 1)
		/ EMPD_CLK_PERIOD_NS;
	localparam int EMPD_WS_STEP_CYC = (EMPD_WS_STEP_CYC_RAW < 1) ? 1 : EMPD_WS_STEP_CYC_RAW;
	localparam logic [2:0] EMPD_WS_MIN = 3'h1;
	// Cycles that the pin word needs to cross the two-stage synchroniser.
	localparam logic [3:0] EMPD_SYNC_CYC = 4'h2;

	// Bus answers.
	localparam logic [1:0] EMPD_RESP_OKAY = 2'h0;
	localparam logic [1:0] EMPD_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		EMPD_IDLE = 2'b00,
		EMPD_STROBE = 2'b01,
		EMPD_DONE = 2'b10
	} empd_state_e;

endpackage

// ---- test/empd_sram_model.sv ----
`timescale 1ns/10ps
module empd_sram_model
(
	// Address and control pins.
	input wire logic [18:1] ext_addr,
	input wire logic low_byte_enable_n,
	input wire logic high_byte_enable_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic paged_window_select_n,
	input wire logic ram_chip_select_n,
	input wire logic rom_chip_select_n,
	// Data pins and speed grade.
	input wire logic [15:0] ext_data_out,
	output logic [15:0] ext_data_in,
	input wire logic slow
);
	logic [15:0] mem [logic [17:0]];
	logic [15:0] w;
	logic sel;

	// Strobes may move with no select low, so the part only acts when selected.
	assign sel = !(paged_window_select_n && ram_chip_select_n && rom_chip_select_n);

	// Unwritten words read as a pattern made from their address.
	function automatic logic [15:0] peek(input logic [17:0] a);
		return mem.exists(a) ? mem[a] : (a[15:0] ^ 16'h5A5A);
	endfunction

	// The boot marker sits at the word that 0xC100 reaches after reset.
	initial
	begin
		ext_data_in = 16'h0000;
		mem[18'h3E080] = 16'hC3B6;
	end

	// Until the access time runs out the bus shows the inverse, never a stale word.
	always @(read_strobe_n or sel or ext_addr or slow)
	begin
		ext_data_in = ~ext_data_in;
		if (sel && !read_strobe_n)
			ext_data_in <= #(slow ? 60 : 12) peek(ext_addr);
	end

	// Writes land at the strobe's rising edge, byte lane by byte lane.
	always @(posedge write_strobe_n)
	begin
		if (sel)
		begin
			w = peek(ext_addr);
			if (!low_byte_enable_n)
				w[7:0] = ext_data_out[7:0];
			if (!high_byte_enable_n)
				w[15:8] = ext_data_out[15:8];
			mem[ext_addr] = w;
		end
	end
endmodule

// ---- test/tb_ext_memory_paging_decode.sv ----
`timescale 1ns/10ps
module tb_ext_memory_paging_decode import empd_pkg::*; ;
	logic aclk, aresetn, slow, cpu_req, cpu_we, cpu_ack, cpu_ext, ext_data_oe;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata, s_axi_rdata, axd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, cpu_be, be_s, resp;
	logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, dma_addr, dma_int_addr;
	logic [15:0] ext_data_in, ext_data_out, rd_s, pg_lo, pg_hi;
	logic [18:1] ext_addr;
	logic [17:0] adr_s;
	logic read_strobe_n, write_strobe_n, low_byte_enable_n, high_byte_enable_n;
	logic paged_window_select_n, ram_chip_select_n, rom_chip_select_n;
	logic [2:0] sel_s;
	logic ext_s, up_en, oe_s;
	int num_errors, comparisons, n_low;

	empd_ext_mem empd_ext_mem_inst (.*);
	empd_sram_model empd_sram_model_inst (.*);

	// Free-running 40 MHz clock.
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Verdict and end of run.
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// A wait that never ends is a failure of its own.
	task automatic hang();
		num_errors++;
		$display("timeout at %0t", $time);
		report_and_stop();
	endtask

	// Value comparison.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Expected pin address: window bank, otherwise plain, A[18:15] high until enabled.
	function automatic logic [17:0] exp_addr(input logic [15:0] a);
		logic [17:0] r;
		r = {3'h0, a[15:1]};
		if (a >= EMPD_WIN_LO && a < 16'hA000)
			r = {pg_lo[5:0], a[12:1]};
		else if (a >= 16'hA000 && a <= EMPD_WIN_HI)
			r = {pg_hi[5:0], a[12:1]};
		if (!up_en)
			r[17:14] = 4'hF;
		return r;
	endfunction

	// Expected selects {paged, ram, rom}, active high.
	function automatic logic [2:0] exp_sel(input logic [15:0] a, input logic rm, input logic om);
		logic [2:0] e;
		e[2] = a >= EMPD_WIN_LO && a <= EMPD_WIN_HI;
		e[1] = a >= EMPD_RAM_LO && a <= (rm ? EMPD_WIN_HI : EMPD_RAM_HI);
		e[0] = a >= (om ? EMPD_WIN_LO : EMPD_ROM_LO) && a <= EMPD_ROM_HI;
		if (a >= EMPD_HOLE_LO && a <= EMPD_HOLE_HI)
			e[0] = 1'b0;
		return e;
	endfunction

	// Register write; both channels offered together, response awaited.
	task automatic axi_wr(input logic [15:0] idx, input logic [15:0] d);
		int n;
		logic b;
		n = 0;
		b = 1'b1;
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'h3;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (b)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
			begin
				b = 1'b0;
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
			n++;
			if (n > 100)
				hang();
		end
		@(posedge aclk);
	endtask

	// Register read.
	task automatic axi_rd(input logic [15:0] idx);
		int n;
		logic b;
		n = 0;
		b = 1'b1;
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (b)
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
			begin
				b = 1'b0;
				axd = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
			n++;
			if (n > 100)
				hang();
		end
		@(posedge aclk);
	endtask

	// Processor access; pins are watched mid-cycle while the strobe is low.
	task automatic cpu_rw(input logic we, input logic [15:0] a, input logic [15:0] d,
		input logic [1:0] be);
		int n;
		n = 0;
		n_low = 0;
		sel_s = 3'h0;
		oe_s = ~we;
		cpu_req <= 1'b1;
		cpu_we <= we;
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_be <= be;
		@(negedge aclk);
		while (cpu_ack !== 1'b1)
		begin
			if ((we ? write_strobe_n : read_strobe_n) === 1'b0)
			begin
				n_low++;
				sel_s = ~{paged_window_select_n, ram_chip_select_n, rom_chip_select_n};
				be_s = {high_byte_enable_n, low_byte_enable_n};
				adr_s = ext_addr;
				oe_s = ext_data_oe;
			end
			n++;
			if (n > 100)
				hang();
			@(negedge aclk);
		end
		rd_s = cpu_rdata;
		ext_s = cpu_ext;
		@(posedge aclk);
		cpu_req <= 1'b0;
		@(posedge aclk);
	endtask

	// Reset values, pins at rest and an unmapped place.
	task automatic t_reset();
		@(negedge aclk);
		chk(ext_addr, 18'h3C000);
		chk({read_strobe_n, write_strobe_n, paged_window_select_n}, 3'h7);
		@(posedge aclk);
		axi_rd(EMPD_IDX_CTRL);
		chk(axd, EMPD_CTRL_RST);
		axi_rd(EMPD_IDX_PAGE_LO);
		chk(axd, EMPD_PAGE_RST);
		axi_rd(EMPD_IDX_UPPER);
		chk(axd, EMPD_UPPER_RST);
		axi_rd(16'h0100);
		chk(resp, EMPD_RESP_SLVERR);
		chk(axd, 32'h0);
		axi_wr(16'h0101, 16'hFFFF);
		chk(resp, EMPD_RESP_SLVERR);
	endtask

	// Boot fetch, then every wait-state count with a slow part at the top one.
	task automatic t_waits();
		axi_wr(EMPD_IDX_CTRL, 16'h0027);
		cpu_rw(1'b0, EMPD_ROM_LO, 16'h0, 2'h3);
		chk({ext_s, rd_s}, {1'b1, 16'hC3B6});
		chk(adr_s, exp_addr(EMPD_ROM_LO));
		for (int ws = 0; ws < 8; ws++)
		begin
			axi_wr(EMPD_IDX_CTRL, 16'h0020 | ws[15:0]);
			slow <= (ws == 7);
			cpu_rw(1'b0, EMPD_RAM_LO, 16'h0, 2'h3);
			chk(n_low, 1 + ((ws < 1) ? 1 : ws) * EMPD_WS_STEP_CYC);
			chk(rd_s, 16'(exp_addr(EMPD_RAM_LO)) ^ 16'h5A5A);
		end
		slow <= 1'b0;
	endtask

	// Chip selects over range edges for all four merge settings.
	task automatic t_decode();
		logic [15:0] tbl [11] = '{16'h3FFF, 16'h4000, 16'h7FFF, 16'h8000, 16'h9FFF,
			16'hA000, 16'hBFFF, 16'hC0FF, 16'hC100, 16'hDFFF, 16'hE000};
		logic [2:0] e;
		for (int m = 0; m < 4; m++)
		begin
			axi_wr(EMPD_IDX_CTRL, 16'h0021 | {11'h0, m[1:0], 3'h0});
			for (int i = 0; i < 11; i++)
			begin
				cpu_rw(1'b0, tbl[i], 16'h0, 2'h3);
				e = exp_sel(tbl[i], m[0], m[1]);
				chk(sel_s, e);
				chk(ext_s, |e);
			end
		end
	endtask

	// Banked windows, top of the extended space, byte lanes and 8-bit A0.
	task automatic t_paging();
		logic [15:0] k;
		up_en = 1'b1;
		pg_lo = 16'h002A;
		pg_hi = 16'h003F;
		axi_wr(EMPD_IDX_UPPER, 16'h0001);
		axi_wr(EMPD_IDX_PAGE_LO, pg_lo);
		axi_wr(EMPD_IDX_PAGE_HI, pg_hi);
		axi_rd(EMPD_IDX_PAGE_HI);
		chk(axd, 32'h3F);
		cpu_rw(1'b1, 16'h8002, 16'h1234, 2'h3);
		chk(adr_s, exp_addr(16'h8002));
		chk(oe_s, 1'b1);
		cpu_rw(1'b1, 16'hBFFE, 16'hBEEF, 2'h3);
		chk(adr_s, 18'h3FFFF);
		pg_lo = 16'h0015;
		axi_wr(EMPD_IDX_PAGE_LO, pg_lo);
		cpu_rw(1'b0, 16'h8002, 16'h0, 2'h3);
		chk(rd_s, 16'(exp_addr(16'h8002)) ^ 16'h5A5A);
		chk(oe_s, 1'b0);
		cpu_rw(1'b0, 16'hBFFE, 16'h0, 2'h3);
		chk(rd_s, 16'hBEEF);
		cpu_rw(1'b1, 16'h4010, 16'hAA55, 2'h1);
		chk(be_s, 2'h2);
		cpu_rw(1'b0, 16'h4010, 16'h0, 2'h3);
		k = 16'(exp_addr(16'h4010)) ^ 16'h5A5A;
		chk(rd_s, {k[15:8], 8'h55});
		axi_wr(EMPD_IDX_CTRL, 16'h0001);
		cpu_rw(1'b0, 16'h4011, 16'h0, 2'h3);
		chk(be_s[0], 1'b1);
		chk(rd_s, 16'h5500);
		cpu_rw(1'b0, 16'h4010, 16'h0, 2'h3);
		chk(be_s[0], 1'b0);
		chk(rd_s, 16'h0055);
	endtask

	// DMA addresses aimed outside are folded into internal space.
	task automatic t_dma();
		dma_addr <= 16'h8000;
		@(posedge aclk);
		@(negedge aclk);
		chk(dma_int_addr, 16'h8000 & EMPD_DMA_MASK);
		@(posedge aclk);
		dma_addr <= 16'hFFFF;
		@(posedge aclk);
		@(negedge aclk);
		chk(dma_int_addr, 16'hFFFF & EMPD_DMA_MASK);
		@(posedge aclk);
		dma_addr <= 16'h1234;
		@(posedge aclk);
		@(negedge aclk);
		chk(dma_int_addr, 16'h1234);
	endtask

	// Main sequence: quiet inputs, 16 cycles of reset, then the scenarios.
	initial
	begin
		num_errors = 0;
		comparisons = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{cpu_req, cpu_we, cpu_addr, cpu_wdata, cpu_be, dma_addr, slow} = '0;
		{pg_lo, pg_hi, up_en} = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_waits();
		t_decode();
		t_paging();
		t_dma();
		report_and_stop();
	end
endmodule
